// ### src/cec_counters.sv
/*
  Cycle stamp counter, counter control register, two event counters and
  test registers, reached by index through the core's register instructions.
  Assumes the core presents one instruction per valid cycle on clk_i and
  takes the answer one cycle later; event lines are same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cec_regs.svh"

module cec_counters
  import cec_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_opcode_i,
  input wire logic [31:0] index_i,
  input wire logic [31:0] src_hi_i,
  input wire logic [31:0] src_lo_i,
  input wire logic [1:0] cpl_i,
  input wire logic stamp_disable_i,
  input wire logic counter_read_enable_i,
  input wire logic [127:0] event_i,
  output logic done_o,
  output logic fault_o,
  output logic [31:0] result_hi_o,
  output logic [31:0] result_lo_o,
  output logic indicator_zero_o,
  output logic indicator_one_o
);
  logic [63:0] stamp_ff;
  logic [31:0] ctl_ff;
  logic [31:0] test_data_ff;
  logic [31:0] test_addr_ff;
  logic [31:0] test_cmd_ff;
  logic done_ff;
  logic fault_ff;
  logic [31:0] res_hi_ff;
  logic [31:0] res_lo_ff;

  cec_kind_t kind;
  logic top_level;
  logic idx_hit;
  logic [63:0] idx_data;
  logic allowed;
  logic [63:0] nxt_result;
  logic wr_go;
  logic [63:0] wr_val;

  cec_ctr_if c0_if();
  cec_ctr_if c1_if();

  assign kind = cec_decode(instr_opcode_i);
  assign top_level = (cpl_i == `CEC_CPL_TOP);
  assign wr_val = {src_hi_i, src_lo_i};

  // Indexed view of every register
  always_comb begin
    idx_hit = 1'b1;
    idx_data = 64'h0;
    case (index_i)
      `CEC_IDX_TEST_DATA: idx_data = {32'h0, test_data_ff};
      `CEC_IDX_TEST_ADDR: idx_data = {32'h0, test_addr_ff};
      `CEC_IDX_TEST_CMD: idx_data = {32'h0, test_cmd_ff};
      `CEC_IDX_STAMP: idx_data = stamp_ff;
      `CEC_IDX_CTL: idx_data = {32'h0, ctl_ff};
      `CEC_IDX_CTR0: idx_data = {16'h0, c0_if.count};
      `CEC_IDX_CTR1: idx_data = {16'h0, c1_if.count};
      default: idx_hit = 1'b0;
    endcase
  end

  // Access check and answer value per instruction kind
  always_comb begin
    allowed = 1'b0;
    nxt_result = 64'h0;
    case (kind)
      CEC_K_MREAD: begin
        allowed = top_level & idx_hit;
        nxt_result = idx_data;
      end
      CEC_K_MWRITE: begin
        allowed = top_level & idx_hit;
      end
      CEC_K_STAMP: begin
        allowed = ~stamp_disable_i | top_level;
        nxt_result = stamp_ff;
      end
      CEC_K_CREAD: begin
        allowed = counter_read_enable_i | top_level;
        // Only the low index bit is decoded; other bits are don't-care
        nxt_result = index_i[`CEC_CTR_SEL_BIT] ? {16'h0, c1_if.count}
                                               : {16'h0, c0_if.count};
      end
      default: begin
        allowed = 1'b0;
        nxt_result = 64'h0;
      end
    endcase
  end

  assign wr_go = instr_valid_i & (kind == CEC_K_MWRITE) & allowed;

  // Free-running on the core clock; suspend or shutdown never gate it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stamp_ff <= `CEC_STAMP_RST;
    end else if (wr_go && index_i == `CEC_IDX_STAMP) begin
      stamp_ff <= wr_val;
    end else begin
      stamp_ff <= stamp_ff + 64'h1;
    end
  end

  // Reserved bits are dropped on write so they always read zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_ff <= `CEC_CTL_RST;
    end else if (wr_go && index_i == `CEC_IDX_CTL) begin
      ctl_ff <= src_lo_i & `CEC_CTL_WMASK;
    end
  end

  // Test registers are plain storage here; their array side effects live elsewhere
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      test_data_ff <= `CEC_TEST_RST;
      test_addr_ff <= `CEC_TEST_RST;
      test_cmd_ff <= `CEC_TEST_RST;
    end else if (wr_go) begin
      if (index_i == `CEC_IDX_TEST_DATA) begin
        test_data_ff <= src_lo_i;
      end
      if (index_i == `CEC_IDX_TEST_ADDR) begin
        test_addr_ff <= src_lo_i;
      end
      if (index_i == `CEC_IDX_TEST_CMD) begin
        test_cmd_ff <= src_lo_i;
      end
    end
  end

  // One-cycle answer: done for allowed instructions, fault for refused ones
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      done_ff <= instr_valid_i & (kind != CEC_K_NONE) & allowed;
      fault_ff <= instr_valid_i & (kind != CEC_K_NONE) & ~allowed;
    end
  end

  // Result holds until the next read-type answer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_hi_ff <= 32'h0;
      res_lo_ff <= 32'h0;
    end else if (instr_valid_i && allowed && kind != CEC_K_MWRITE && kind != CEC_K_NONE) begin
      res_hi_ff <= nxt_result[63:32];
      res_lo_ff <= nxt_result[31:0];
    end
  end

  // Field split of the shared control register
  assign c0_if.sel = {ctl_ff[`CEC_Z_SEL_HI], ctl_ff[`CEC_Z_SEL_LO]};
  assign c0_if.en_below3 = ctl_ff[`CEC_Z_BELOW3];
  assign c0_if.en_level3 = ctl_ff[`CEC_Z_LEVEL3];
  assign c0_if.is_timer = ctl_ff[`CEC_Z_TYPE];
  assign c0_if.ovf_mode = ctl_ff[`CEC_Z_IND];
  assign c0_if.current_privilege_level = cpl_i;
  assign c0_if.wr_en = wr_go & (index_i == `CEC_IDX_CTR0);
  assign c0_if.wr_data = wr_val[47:0];

  assign c1_if.sel = {ctl_ff[`CEC_O_SEL_HI], ctl_ff[`CEC_O_SEL_LO]};
  assign c1_if.en_below3 = ctl_ff[`CEC_O_BELOW3];
  assign c1_if.en_level3 = ctl_ff[`CEC_O_LEVEL3];
  assign c1_if.is_timer = ctl_ff[`CEC_O_TYPE];
  assign c1_if.ovf_mode = ctl_ff[`CEC_O_IND];
  assign c1_if.current_privilege_level = cpl_i;
  assign c1_if.wr_en = wr_go & (index_i == `CEC_IDX_CTR1);
  assign c1_if.wr_data = wr_val[47:0];

  // Two independent counters on one control register
  cec_event_counter u_ctr0 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(event_i),
    .cif(c0_if)
  );

  cec_event_counter u_ctr1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(event_i),
    .cif(c1_if)
  );

  assign done_o = done_ff;
  assign fault_o = fault_ff;
  assign result_hi_o = res_hi_ff;
  assign result_lo_o = res_lo_ff;
  assign indicator_zero_o = c0_if.indicator;
  assign indicator_one_o = c1_if.indicator;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_stamp_free_run: assert property (
      !(wr_go && index_i == `CEC_IDX_STAMP) |=> stamp_ff == $past(stamp_ff) + 64'h1)
    else $error("stamp did not advance");
  a_stamp_write_load: assert property (
      wr_go && index_i == `CEC_IDX_STAMP |=> stamp_ff == $past(wr_val))
    else $error("stamp write not applied");
  a_mreg_priv_fault: assert property (
      instr_valid_i && (kind == CEC_K_MREAD || kind == CEC_K_MWRITE) && cpl_i != `CEC_CPL_TOP
      |=> fault_o && !done_o)
    else $error("register access allowed below level zero");
  a_stamp_read_gate: assert property (
      instr_valid_i && kind == CEC_K_STAMP && stamp_disable_i && cpl_i != `CEC_CPL_TOP
      |=> fault_o)
    else $error("stamp read not refused");
  a_stamp_read_data: assert property (
      instr_valid_i && kind == CEC_K_STAMP && !stamp_disable_i
      |=> done_o && {result_hi_o, result_lo_o} == $past(stamp_ff))
    else $error("stamp read value wrong");
  a_ctr_read_gate: assert property (
      instr_valid_i && kind == CEC_K_CREAD && !counter_read_enable_i && cpl_i != `CEC_CPL_TOP
      |=> (fault_o && !done_o) ##1 (!fault_o || $past(instr_valid_i)))
    else $error("counter read not refused");
  a_ctr_read_sel: assert property (
      instr_valid_i && kind == CEC_K_CREAD && (counter_read_enable_i || top_level)
      && index_i[0]
      |=> result_hi_o[31:16] == 16'h0
          && {result_hi_o[15:0], result_lo_o} == $past(c1_if.count))
    else $error("counter read chose wrong counter");
  a_mread_data: assert property (
      instr_valid_i && kind == CEC_K_MREAD && top_level && index_i == `CEC_IDX_CTL
      |=> done_o && result_lo_o == $past(ctl_ff) && result_hi_o == 32'h0)
    else $error("control read value wrong");
  a_ctl_reserved: assert property (ctl_ff[15:11] == 5'h0)
    else $error("reserved control bits set");
  a_ctl_write_mask: assert property (
      wr_go && index_i == `CEC_IDX_CTL |=> ctl_ff == ($past(src_lo_i) & `CEC_CTL_WMASK))
    else $error("control write not applied");
  a_answer_one_cycle: assert property (done_o |=> !done_o || $past(instr_valid_i))
    else $error("done held without request");

  // Answer coding and refusal
  a_done_fault_excl: assert property (!(done_o && fault_o))
    else $error("done and fault together");

  a_unknown_ignored: assert property (
      instr_valid_i && kind == CEC_K_NONE |=> !done_o && !fault_o)
    else $error("unknown opcode answered");

  a_unmapped_fault: assert property (
      instr_valid_i && (kind == CEC_K_MREAD || kind == CEC_K_MWRITE) && !idx_hit
      |=> fault_o && !done_o)
    else $error("unmapped index not refused");

  a_mwrite_done: assert property (
      instr_valid_i && kind == CEC_K_MWRITE && top_level && idx_hit
      |=> done_o && !fault_o)
    else $error("register write not completed");

  a_refused_no_write: assert property (
      instr_valid_i && kind == CEC_K_MWRITE && !top_level
      |=> $stable(ctl_ff) && $stable(test_data_ff))
    else $error("refused write changed a register");

  a_stamp_open_user: assert property (
      instr_valid_i && kind == CEC_K_STAMP && !stamp_disable_i && cpl_i == `CEC_CPL_USER
      |=> done_o && !fault_o)
    else $error("stamp read refused while open");

  a_ctr_read_open: assert property (
      instr_valid_i && kind == CEC_K_CREAD && counter_read_enable_i |=> done_o)
    else $error("counter read refused while enabled");

  // Data paths of the answer and of writes
  a_ctr0_read_sel: assert property (
      instr_valid_i && kind == CEC_K_CREAD && (counter_read_enable_i || top_level)
      && !index_i[0]
      |=> {result_hi_o, result_lo_o} == {16'h0, $past(c0_if.count)})
    else $error("counter read missed counter zero");

  a_ctr_read_hi_zero: assert property (
      instr_valid_i && kind == CEC_K_MREAD && top_level
      && (index_i == `CEC_IDX_CTR0 || index_i == `CEC_IDX_CTR1)
      |=> result_hi_o[31:16] == 16'h0)
    else $error("counter upper result bits not zero");

  a_mread_stamp: assert property (
      instr_valid_i && kind == CEC_K_MREAD && top_level && index_i == `CEC_IDX_STAMP
      |=> done_o && {result_hi_o, result_lo_o} == $past(stamp_ff))
    else $error("stamp register read value wrong");

  a_result_hold: assert property (
      !(instr_valid_i && allowed && (kind == CEC_K_MREAD || kind == CEC_K_STAMP
        || kind == CEC_K_CREAD)) |=> $stable(result_hi_o) && $stable(result_lo_o))
    else $error("result changed without a read");

  a_test_data_load: assert property (
      wr_go && index_i == `CEC_IDX_TEST_DATA |=> test_data_ff == $past(src_lo_i))
    else $error("test data write not applied");

  a_test_addr_load: assert property (
      wr_go && index_i == `CEC_IDX_TEST_ADDR |=> test_addr_ff == $past(src_lo_i))
    else $error("test address write not applied");

  a_test_cmd_load: assert property (
      wr_go && index_i == `CEC_IDX_TEST_CMD |=> test_cmd_ff == $past(src_lo_i))
    else $error("test command write not applied");

  a_ctr1_write_load: assert property (
      wr_go && index_i == `CEC_IDX_CTR1
      |=> c1_if.count == $past(wr_val[47:0]))
    else $error("counter one write not applied");
endmodule // cec_counters

`default_nettype wire

// ### src/cec_regs.svh
/*
  Index map, control field positions, reset values and instruction codes
  of the cycle and event counter block. Assumes it is included by bare name.
*/
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH

`define CEC_IDX_TEST_DATA 32'h0000_0003
`define CEC_IDX_TEST_ADDR 32'h0000_0004
`define CEC_IDX_TEST_CMD 32'h0000_0005
`define CEC_IDX_STAMP 32'h0000_0010
`define CEC_IDX_CTL 32'h0000_0011
`define CEC_IDX_CTR0 32'h0000_0012
`define CEC_IDX_CTR1 32'h0000_0013

`define CEC_OP_MREG_WRITE 16'h0f30
`define CEC_OP_STAMP_READ 16'h0f31
`define CEC_OP_MREG_READ 16'h0f32
`define CEC_OP_CTR_READ 16'h0f33

`define CEC_CTL_WMASK 32'h07ff_07ff
`define CEC_CTL_RST 32'h0000_0000
`define CEC_TEST_RST 32'h0000_0000
`define CEC_CNT_RST 48'h0000_0000_0000
`define CEC_STAMP_RST 64'h0000_0000_0000_0000

`define CEC_Z_SEL_LO 5:0
`define CEC_Z_BELOW3 6
`define CEC_Z_LEVEL3 7
`define CEC_Z_TYPE 8
`define CEC_Z_IND 9
`define CEC_Z_SEL_HI 10
`define CEC_O_SEL_LO 21:16
`define CEC_O_BELOW3 22
`define CEC_O_LEVEL3 23
`define CEC_O_TYPE 24
`define CEC_O_IND 25
`define CEC_O_SEL_HI 26

`define CEC_CPL_TOP 2'h0
`define CEC_CPL_USER 2'h3
`define CEC_CTR_SEL_BIT 0

`endif

// ### src/cec_pkg.sv
/*
  Types shared by the counter block: decoded instruction kinds.
  Assumes cec_regs.svh is on the include path.
*/
`include "cec_regs.svh"

package cec_pkg;
  typedef enum logic [4:0] {
    CEC_K_NONE = 5'h01,
    CEC_K_MREAD = 5'h02,
    CEC_K_MWRITE = 5'h04,
    CEC_K_STAMP = 5'h08,
    CEC_K_CREAD = 5'h10
  } cec_kind_t;

  function automatic cec_kind_t cec_decode(input logic [15:0] op);
    case (op)
      `CEC_OP_MREG_READ: cec_decode = CEC_K_MREAD;
      `CEC_OP_MREG_WRITE: cec_decode = CEC_K_MWRITE;
      `CEC_OP_STAMP_READ: cec_decode = CEC_K_STAMP;
      `CEC_OP_CTR_READ: cec_decode = CEC_K_CREAD;
      default: cec_decode = CEC_K_NONE;
    endcase
  endfunction
endpackage

// ### src/cec_ctr_if.sv
/*
  Carrier between the register side and one 48-bit event counter.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface cec_ctr_if;
  logic wr_en;
  logic [47:0] wr_data;
  logic [6:0] sel;
  logic is_timer;
  logic en_below3;
  logic en_level3;
  logic ovf_mode;
  logic [1:0] current_privilege_level;
  logic [47:0] count;
  logic indicator;
  modport ctl (output wr_en, wr_data, sel, is_timer, en_below3, en_level3, ovf_mode, current_privilege_level,
               input count, indicator);
  modport ctr (input wr_en, wr_data, sel, is_timer, en_below3, en_level3, ovf_mode, current_privilege_level,
               output count, indicator);
endinterface : cec_ctr_if

`default_nettype wire

// ### src/cec_event_counter.sv
/*
  One 48-bit event or duration counter with its indicator pin flop.
  Assumes event lines come from logic on the same clock, one bit per
  event number; duration events are held high while their condition lasts.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cec_regs.svh"

module cec_event_counter
  import cec_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [127:0] event_i,
  cec_ctr_if.ctr cif
);
  logic [47:0] count_ff;
  logic ind_ff;
  logic gate;
  logic hit;
  logic inc;
  logic ovf;

  assign gate = (cif.current_privilege_level == `CEC_CPL_USER) ? cif.en_level3 : cif.en_below3;
  assign hit = cif.is_timer | event_i[cif.sel];
  assign inc = gate & hit;
  assign ovf = inc & (&count_ff) & ~cif.wr_en;

  // A write wins over a same-cycle increment so software sees its value
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_ff <= `CEC_CNT_RST;
    end else if (cif.wr_en) begin
      count_ff <= cif.wr_data;
    end else if (inc) begin
      count_ff <= count_ff + 48'h1;
    end
  end

  // Event mode shows each incrementing cycle, so a held duration event keeps it high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ind_ff <= 1'b0;
    end else begin
      ind_ff <= cif.ovf_mode ? ovf : inc;
    end
  end

  assign cif.count = count_ff;
  assign cif.indicator = ind_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_ctr_wrap_zero: assert property (ovf |=> count_ff == 48'h0 && ind_ff)
    else $error("counter did not wrap to zero");
  a_ctr_load_val: assert property (cif.wr_en |=> count_ff == $past(cif.wr_data))
    else $error("counter write not applied");
  a_ctr_gated_hold: assert property (!gate && !cif.wr_en |=> $stable(count_ff))
    else $error("counter moved while gated off");
  a_ind_event_mode: assert property (
      !cif.ovf_mode && gate && event_i[cif.sel] && !cif.wr_en |=> ind_ff)
    else $error("indicator missed an event");
  a_timer_counts: assert property (cif.is_timer && gate && !cif.wr_en && !(&count_ff)
                                   |=> count_ff == $past(count_ff) + 48'h1)
    else $error("timer mode did not count");
endmodule // cec_event_counter

`default_nettype wire

// ### bench/cec_core_model.sv
/*
  Core-side model: issues one instruction at a time and holds the
  privilege level and the two read flags that the counter block sees.
  Assumes clk_i is the core clock and answers come one cycle after taking.
*/
`timescale 1ns/1ps
`default_nettype none

module cec_core_model (
  input wire logic clk_i,
  input wire logic done_i,
  input wire logic fault_i,
  input wire logic [31:0] res_hi_i,
  input wire logic [31:0] res_lo_i,
  output logic valid_o,
  output logic [15:0] op_o,
  output logic [31:0] idx_o,
  output logic [31:0] src_hi_o,
  output logic [31:0] src_lo_o,
  output logic [1:0] cpl_o,
  output logic stamp_dis_o,
  output logic rd_en_o
);
  int unsigned cyc = 0;

  always @(posedge clk_i) cyc <= cyc + 1;

  initial begin
    valid_o = 1'b0;
    op_o = 16'h0;
    idx_o = 32'h0;
    src_hi_o = 32'h0;
    src_lo_o = 32'h0;
    cpl_o = 2'h0;
    stamp_dis_o = 1'b0;
    rd_en_o = 1'b0;
  end

  // Held from one falling edge to the next, so stable at the taking edge
  task automatic issue(input logic [15:0] op, input logic [31:0] idx, input logic [31:0] hi,
                       input logic [31:0] lo, input logic [1:0] lvl, output logic dn,
                       output logic fl, output logic [63:0] res, output int unsigned at);
    @(negedge clk_i);
    valid_o = 1'b1;
    op_o = op;
    idx_o = idx;
    src_hi_o = hi;
    src_lo_o = lo;
    cpl_o = lvl;
    at = cyc + 1;
    @(negedge clk_i);
    valid_o = 1'b0;
    // Released operands are scrambled so a stale value cannot pass
    idx_o = ~idx;
    src_hi_o = ~hi;
    src_lo_o = ~lo;
    dn = done_i;
    fl = fault_i;
    res = {res_hi_i, res_lo_i};
  endtask
endmodule // cec_core_model

`default_nettype wire

// ### bench/cec_counters_test.sv
/*
  Self-checking bench of the counter block, driven through the core model.
  Assumes the design answers each instruction one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cec_regs.svh"

module cec_counters_test;
  logic clk, rst, valid, dn, fl, sd, re, i0, i1, d1, f1;
  logic [15:0] op;
  logic [31:0] idx, shi, slo, rhi, rlo, lf;
  logic [1:0] current_privilege_level;
  logic [127:0] ev;
  logic [63:0] r1, r2, e1;
  logic [47:0] p0;
  logic mon;
  int unsigned err_count, cmp_count, tcnt, a1, a2, n0, n1, q0, q1;
  logic [31:0] ix [6] = '{32'h3, 32'h4, 32'h5, 32'h11, 32'h12, 32'h13};

  cec_counters cec_counters_i (.clk_i(clk), .sys_rst_i(rst), .instr_valid_i(valid),
    .instr_opcode_i(op), .index_i(idx), .src_hi_i(shi), .src_lo_i(slo), .cpl_i(current_privilege_level),
    .stamp_disable_i(sd), .counter_read_enable_i(re), .event_i(ev), .done_o(dn),
    .fault_o(fl), .result_hi_o(rhi), .result_lo_o(rlo), .indicator_zero_o(i0),
    .indicator_one_o(i1));

  cec_core_model cec_core_model_i (.clk_i(clk), .done_i(dn), .fault_i(fl), .res_hi_i(rhi),
    .res_lo_i(rlo), .valid_o(valid), .op_o(op), .idx_o(idx), .src_hi_o(shi), .src_lo_o(slo),
    .cpl_o(current_privilege_level), .stamp_dis_o(sd), .rd_en_o(re));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic go(input logic [15:0] o, input logic [31:0] x, input logic [63:0] src,
                    input logic [1:0] lvl, input logic ef, input logic [63:0] er, input logic ck);
    logic d, f;
    logic [63:0] res;
    int unsigned at;
    cec_core_model_i.issue(o, x, src[63:32], src[31:0], lvl, d, f, res, at);
    chk("done", {63'h0, d}, {63'h0, !ef && o[15:2] == 14'h03cc});
    chk("fault", {63'h0, f}, {63'h0, ef});
    if (ck)
      chk("result", res, er);
  endtask

  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    if (tcnt >= 3000) begin
      err_count++;
      end_sim();
    end
  end

  always @(negedge clk) begin
    if (mon) begin
      q0 += i0;
      q1 += i1;
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ev = '0;
    lf = 32'h0eb3;
    mon = 1'b0;
    {err_count, cmp_count, tcnt, q0, q1, n0, n1} = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (ix[i]) go(`CEC_OP_MREG_READ, ix[i], 64'h0, 2'h0, 1'b0, 64'h0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      go(`CEC_OP_MREG_WRITE, 32'h3 + i, {lf, ~lf}, 2'h0, 1'b0, 64'h0, 1'b0);
      go(`CEC_OP_MREG_READ, 32'h3 + i, 64'h0, 2'h0, 1'b0, {32'h0, ~lf}, 1'b1);
    end
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTL, '1, 2'h0, 1'b0, 64'h0, 1'b0);
    go(`CEC_OP_MREG_READ, `CEC_IDX_CTL, 64'h0, 2'h0, 1'b0, 64'h07ff_07ff, 1'b1);
    go(`CEC_OP_MREG_READ, 32'h6, 64'h0, 2'h0, 1'b1, 64'h0, 1'b0);
    go(16'h0f34, `CEC_IDX_CTL, 64'h0, 2'h0, 1'b0, 64'h0, 1'b0);
    for (int l = 0; l < 4; l++) begin
      for (int f = 0; f < 2; f++) begin
        cec_core_model_i.stamp_dis_o = f[0];
        cec_core_model_i.rd_en_o = f[0];
        go(`CEC_OP_MREG_READ, `CEC_IDX_CTL, 64'h0, l[1:0], l != 0, 64'h0, 1'b0);
        go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTR0, 64'h0, l[1:0], l != 0, 64'h0, 1'b0);
        go(`CEC_OP_STAMP_READ, 32'h0, 64'h0, l[1:0], f && l != 0, 64'h0, 1'b0);
        go(`CEC_OP_CTR_READ, 32'h0, 64'h0, l[1:0], !f && l != 0, 64'h0, 1'b0);
      end
    end
    cec_core_model_i.stamp_dis_o = 1'b0;
    cec_core_model_i.rd_en_o = 1'b0;
    cec_core_model_i.issue(`CEC_OP_STAMP_READ, 32'h0, 32'h0, 32'h0, 2'h3, d1, f1, r1, a1);
    chk("stamp done", {62'h0, d1, f1}, 64'h2);
    repeat (lf[4:0]) @(negedge clk);
    cec_core_model_i.issue(`CEC_OP_STAMP_READ, 32'h0, 32'h0, 32'h0, 2'h3, d1, f1, r2, a2);
    chk("stamp done", {62'h0, d1, f1}, 64'h2);
    chk("stamp step", r2 - r1, 64'(a2 - a1));
    lf = nx(lf);
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_STAMP, {lf, 32'h0}, 2'h0, 1'b0, 64'h0, 1'b0);
    cec_core_model_i.issue(`CEC_OP_STAMP_READ, 32'h0, 32'h0, 32'h0, 2'h0, d1, f1, r1, a1);
    chk("stamp done", {62'h0, d1, f1}, 64'h2);
    chk("stamp high", {32'h0, r1[63:32]}, {32'h0, lf});
    go(`CEC_OP_MREG_READ, `CEC_IDX_STAMP, 64'h0, 2'h0, 1'b0, 64'h0, 1'b0);
    // Counter zero counts event 45h at level three; counter one times and flags overflow
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTL, 64'h0392_0485, 2'h0, 1'b0, 64'h0, 1'b0);
    lf = nx(lf);
    p0 = {16'h0, lf};
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTR0, {16'h0, p0}, 2'h0, 1'b0, 64'h0, 1'b0);
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTR1, 64'hffff_fff0, 2'h0, 1'b0, 64'h0, 1'b0);
    go(`CEC_OP_MREG_WRITE, `CEC_IDX_CTR1, 64'h0000_ffff_ffff_fff0, 2'h0, 1'b0, 64'h0, 1'b0);
    q0 = 0;
    q1 = 0;
    mon = 1'b1;
    repeat (60) begin
      @(negedge clk);
      lf = nx(lf);
      cec_core_model_i.cpl_o = lf[0] ? 2'h3 : {1'b0, lf[1]};
      ev = {4{lf}};
      n0 += (ev[69] && lf[0]);
      n1 += lf[0];
    end
    @(negedge clk);
    ev = '0;
    cec_core_model_i.cpl_o = 2'h0;
    repeat (2) @(negedge clk);
    mon = 1'b0;
    e1 = 64'h0000_ffff_ffff_fff0 + 64'(n1);
    chk("event pulses", 64'(q0), 64'(n0));
    chk("overflow pulses", 64'(q1), {63'h0, e1[48]});
    go(`CEC_OP_CTR_READ, 32'h0, 64'h0, 2'h0, 1'b0, {16'h0, p0 + 48'(n0)}, 1'b1);
    go(`CEC_OP_CTR_READ, 32'h1, 64'h0, 2'h0, 1'b0, {16'h0, e1[47:0]}, 1'b1);
    go(`CEC_OP_MREG_READ, `CEC_IDX_CTR1, 64'h0, 2'h0, 1'b0, {16'h0, e1[47:0]}, 1'b1);
    end_sim();
  end
endmodule // cec_counters_test

`default_nettype wire
